// File: core/sensor_measurement_sequencer.sv
// measurement sequencer, converter count logic and diagnostic state
// assumes modulator bit and power-on clear arrive from outside the clock domain
`timescale 1ns/10ps
// Function
// - thirteen gain codes, 420 down to 2,8, from stored configuration
// - six-bit stored offset pre-compensation field drives front end
// - offset code spans -31..31; accuracy only within -20..20
// - offset step scales by gain-dependent factor k
// - multiplexer steps offset, bridge, diode, resistor and thermistor inputs
// - pressure measurements per cycle are a power of two, 1..128
// - one stored bit enables the second temperature measurement
// - start routine: auto-zero and pressure, then temperature if enabled
// - first order: 9..14 bits, about 2^r microseconds
// - second order: stacked, 11..15 bits, about 2^((r+3)/2) microseconds
// - count equals 2^r times ratio plus one minus range shift
// - range shift selectable: 15/16, 7/8, 3/4, 1/2
// - supply reference keeps offset enabled with its code at zero
// - output resolution follows converter up to 11 analog, 12 pwm
// - each measurement handed on as a 16 bit value for correction
// - configuration checked against a signature at initialization
// - register parity checked always; error sets flag and diagnostics
// - results tagged so sensor and temperature terms can be corrected
// - diagnostic forces analog output to extreme and serial error code
module sensor_measurement_sequencer
    import sequencer_pkg::*;
#(
    parameter int tick_cycles = TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic power_on_clear,
    input wire logic modulator_bit,
    output logic [3:0] gain_code,
    output logic [15:0] gain_x10,
    output logic offset_enable,
    output logic [5:0] offset_code,
    output logic [15:0] offset_factor,
    output mux_type mux_sel,
    output result_type result,
    output logic result_valid,
    output logic error_flag,
    output logic [10:0] analog_out_code,
    output logic [15:0] serial_word,
    output logic [3:0] analog_res,
    output logic [3:0] pwm_res
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [1:0] sync_meta;
    logic [1:0] sync_out;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_meta <= 2'b00;
            sync_out <= 2'b00;
        end else begin
            sync_meta <= {power_on_clear, modulator_bit};
            sync_out <= sync_meta;
        end
    end
    wire logic poc_s = sync_out[1];
    wire logic mod_s = sync_out[0];

    // ----------------------------------------
    // register file and AXI4-Lite slave
    // ----------------------------------------
    logic run;
    cfg_type cfg;
    logic cfg_par;
    logic [15:0] signature;
    logic sig_par;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic sig_fail;
    state_type state;
    state_type next_state;
    logic conv_active;
    logic [15:0] last_press;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    wire logic wr_go = aw_hold && w_hold && !s_axi_bvalid;
    wire logic wr_ctrl = aw_addr == ADDR_CTRL;
    wire logic wr_cfg = aw_addr == ADDR_CONFIG;
    wire logic wr_sig = aw_addr == ADDR_SIGNATURE;
    wire logic [31:0] cfg_new = merge({3'b000, cfg}, w_data, w_strb);
    wire logic [31:0] sig_new = merge({16'h0000, signature}, w_data, w_strb);
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ctrl || wr_cfg || wr_sig) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // parity kept beside the config and signature words, checked every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= CTRL_RESET;
            cfg <= CONFIG_RESET;
            cfg_par <= ^CONFIG_RESET;
            signature <= SIGNATURE_RESET;
            sig_par <= ^SIGNATURE_RESET;
        end else if (wr_go) begin
            if (wr_ctrl && w_strb[0]) begin
                run <= w_data[0];
            end
            if (wr_cfg) begin
                cfg <= cfg_new[28:0];
                cfg_par <= ^cfg_new[28:0];
            end
            if (wr_sig) begin
                signature <= sig_new[15:0];
                sig_par <= ^sig_new[15:0];
            end
        end
    end
    wire logic parity_err = ((^cfg) != cfg_par) || ((^signature) != sig_par);

    wire logic [31:0] status_word = {24'h0, conv_active, state, sig_fail, parity_err,
                                     error_flag};
    wire logic rd_ok = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_CONFIG ||
                       s_axi_araddr == ADDR_SIGNATURE || s_axi_araddr == ADDR_STATUS ||
                       s_axi_araddr == ADDR_RESULT;
    wire logic [31:0] rd_mux =
        (s_axi_araddr == ADDR_CTRL) ? {31'h0, run} :
        (s_axi_araddr == ADDR_CONFIG) ? {3'b000, cfg} :
        (s_axi_araddr == ADDR_SIGNATURE) ? {16'h0000, signature} :
        (s_axi_araddr == ADDR_STATUS) ? status_word :
        (s_axi_araddr == ADDR_RESULT) ? {13'h0, result} : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // converter count logic
    // ----------------------------------------
    cfg_type cfg_active;
    logic [15:0] tick_cnt;
    logic [16:0] samp;
    logic [15:0] acc1;
    logic [19:0] acc2;
    wire logic [3:0] res_lo = cfg_active.order ? RES2_MIN : RES1_MIN;
    wire logic [3:0] res_hi = cfg_active.order ? RES2_MAX : RES1_MAX;
    wire logic [3:0] r_eff = (cfg_active.res < res_lo) ? res_lo :
                             (cfg_active.res > res_hi) ? res_hi : cfg_active.res;
    wire logic [4:0] r_plus3 = {1'b0, r_eff} + 5'd3;
    wire logic [3:0] e_exp = r_plus3[4:1];
    wire logic [3:0] n_exp = cfg_active.order ? e_exp : r_eff;
    wire logic [16:0] samp_target = 17'h00001 << n_exp;
    wire logic [4:0] sh = {e_exp, 1'b0} - 5'd1 - {1'b0, r_eff};
    wire logic tick = conv_active && tick_cnt == 16'(tick_cycles - 1);
    wire logic conv_done = tick && samp == samp_target - 17'h00001;
    wire logic [15:0] acc1_n = acc1 + {15'h0, mod_s};
    wire logic [19:0] acc2_n = acc2 + {4'h0, acc1_n};
    wire logic [19:0] raw = cfg_active.order ? (acc2_n >> sh) : {4'h0, acc1_n};
    // 1 - range shift is 2^-(4 - code)
    wire logic [2:0] rs_shift = 3'd4 - {1'b0, cfg_active.range_shift};
    wire logic [16:0] offs = (17'h00001 << r_eff) >> rs_shift;
    wire logic [20:0] sum = {1'b0, raw} + {4'h0, offs};
    wire logic [15:0] count = (sum > 21'h00ffff) ? 16'hffff : sum[15:0];

    wire logic meas = !(state == ST_IDLE || state == ST_CHECK || state == ST_ERROR);
    wire logic abort = conv_active && (next_state == ST_IDLE || next_state == ST_ERROR);
    wire logic az_state = state == ST_START_AZ || state == ST_START_AZT ||
                          state == ST_AZP || state == ST_AZT;
    wire logic p_state = state == ST_START_P || state == ST_P;

    function automatic mux_type temp_src(input logic [1:0] s);
        mux_type m;
        case (s)
            2'b00: m = MUX_DIODE;
            2'b01: m = MUX_BRIDGE_RES;
            default: m = MUX_THERMISTOR;
        endcase
        return m;
    endfunction

    wire mux_type start_mux = az_state ? MUX_OFFSET : p_state ? MUX_BRIDGE :
                              (state == ST_T2) ? temp_src(cfg.t2_src) :
                              temp_src(cfg.t1_src);

    // config frozen while a conversion runs, so writes never split one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_active <= 1'b0;
            cfg_active <= CONFIG_RESET;
            mux_sel <= MUX_OFFSET;
            samp <= 17'h0;
            acc1 <= 16'h0;
            acc2 <= 20'h0;
        end else if (conv_done || abort) begin
            conv_active <= 1'b0;
        end else if (meas && !conv_active && next_state == state) begin
            conv_active <= 1'b1;
            cfg_active <= cfg;
            mux_sel <= start_mux;
            samp <= 17'h0;
            acc1 <= 16'h0;
            acc2 <= 20'h0;
        end else if (tick) begin
            samp <= samp + 17'h00001;
            acc1 <= acc1_n;
            acc2 <= acc2_n;
        end else if (!conv_active) begin
            cfg_active <= cfg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !conv_active || tick) begin
            tick_cnt <= 16'h0;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    logic [7:0] p_cnt;
    state_type after_done;
    wire logic p_last = p_cnt == ((8'h01 << cfg_active.plog) - 8'h01);
    wire logic sig_ok = (cfg[15:0] ^ {3'b000, cfg[28:16]} ^ SIG_SEED) == signature;

    always_comb begin
        after_done = state;
        case (state)
            ST_START_AZ: after_done = ST_START_P;
            ST_START_P: after_done = cfg_active.temp_en ? ST_START_AZT : ST_P;
            ST_START_AZT: after_done = ST_START_T;
            ST_START_T: after_done = ST_P;
            ST_P: after_done = p_last ? ST_AZP : ST_P;
            ST_AZP: after_done = cfg_active.temp_en ? ST_AZT : ST_P;
            ST_AZT: after_done = ST_T1;
            ST_T1: after_done = cfg_active.second_temp_enable ? ST_T2 : ST_P;
            default: after_done = ST_P;
        endcase
    end

    assign next_state = parity_err ? ST_ERROR :
                        poc_s ? ST_IDLE :
                        (state == ST_ERROR) ? ST_ERROR :
                        !run ? ST_IDLE :
                        (state == ST_IDLE) ? ST_CHECK :
                        (state == ST_CHECK) ? (sig_ok ? ST_START_AZ : ST_ERROR) :
                        conv_done ? after_done : state;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            error_flag <= 1'b0;
            sig_fail <= 1'b0;
        end else begin
            state <= next_state;
            error_flag <= next_state == ST_ERROR;
            if (state == ST_CHECK && !sig_ok) begin
                sig_fail <= 1'b1;
            end else if (poc_s) begin
                sig_fail <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_valid <= 1'b0;
            result <= '{tag: MUX_OFFSET, count: 16'h0};
            p_cnt <= 8'h00;
            last_press <= 16'h0;
        end else begin
            result_valid <= conv_done;
            if (conv_done) begin
                result <= '{tag: mux_sel, count: count};
                if (mux_sel == MUX_BRIDGE) begin
                    last_press <= count;
                end
                p_cnt <= (state == ST_P && !p_last) ? p_cnt + 8'h01 : 8'h00;
            end
            if (!meas) begin
                p_cnt <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // front-end settings and outputs
    // ----------------------------------------
    wire logic [3:0] gain_idx = (cfg_active.gain > GAIN_MAX) ? GAIN_MAX : cfg_active.gain;
    wire logic [5:0] off_clamp = (cfg_active.offset == OFFSET_NEG_LIMIT) ?
                                 OFFSET_NEG_CLAMP : cfg_active.offset;
    wire logic [3:0] ares_w = (r_eff > ANALOG_RES_MAX) ? ANALOG_RES_MAX : r_eff;
    wire logic [3:0] pres_w = (r_eff > PWM_RES_MAX) ? PWM_RES_MAX : r_eff;
    wire logic [15:0] press_scaled = last_press >> (r_eff - ares_w);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_code <= 4'h0;
            gain_x10 <= 16'h0;
            offset_enable <= 1'b0;
            offset_code <= 6'h00;
            offset_factor <= 16'h0;
            analog_res <= 4'h0;
            pwm_res <= 4'h0;
            analog_out_code <= 11'h000;
            serial_word <= 16'h0;
        end else begin
            gain_code <= gain_idx;
            gain_x10 <= GAIN_X10[gain_idx];
            offset_factor <= K_X1000[gain_idx];
            offset_enable <= cfg_active.xzc_en || cfg_active.ref_supply;
            offset_code <= cfg_active.ref_supply ? 6'h00 : off_clamp;
            analog_res <= ares_w;
            pwm_res <= pres_w;
            if (error_flag) begin
                analog_out_code <= cfg_active.diag_high ? 11'h7ff : 11'h000;
                serial_word <= ERROR_CODE;
            end else begin
                analog_out_code <= press_scaled[10:0];
                serial_word <= last_press;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_offset_zeroed: assert property ($past(cfg_active.ref_supply) |->
        offset_code == 6'h00 && offset_enable) else $error("offset not forced to zero");
    chk_offset_range: assert property (offset_code != OFFSET_NEG_LIMIT)
        else $error("offset code out of range");
    chk_gain_range: assert property (gain_code <= GAIN_MAX)
        else $error("gain code out of range");
    chk_result_pulse: assert property (result_valid |=> !result_valid)
        else $error("result strobe longer than one cycle");
    chk_diag_output: assert property (error_flag |=> serial_word == ERROR_CODE &&
        (analog_out_code == 11'h7ff || analog_out_code == 11'h000))
        else $error("diagnostic outputs not forced");
    chk_poc_restart: assert property (poc_s && !parity_err |=> state == ST_IDLE
        ##1 !conv_active) else $error("power-on clear did not restart");
    chk_start_first: assert property (state == ST_CHECK && sig_ok && run && !poc_s &&
        !parity_err |=> state == ST_START_AZ ##1 mux_sel == MUX_OFFSET)
        else $error("start routine not entered");
    chk_res_limits: assert property (conv_active |-> (cfg_active.order ?
        (r_eff >= RES2_MIN && r_eff <= RES2_MAX) : (r_eff >= RES1_MIN && r_eff <= RES1_MAX)))
        else $error("resolution outside mode range");
    chk_output_res: assert property (analog_res <= ANALOG_RES_MAX &&
        pwm_res <= PWM_RES_MAX) else $error("output resolution too wide");
    chk_temp2_gate: assert property (state == ST_T2 && $past(state) == ST_T1 |->
        $past(cfg_active.second_temp_enable)) else $error("second temperature not enabled");
    chk_parity_error: assert property (parity_err |=> error_flag)
        else $error("parity error not flagged");

    cov_start_done: cover property (state == ST_START_T ##1 state == ST_P);
    cov_second_temp: cover property (state == ST_T2 && conv_done);
    cov_sig_fail: cover property (state == ST_CHECK ##1 state == ST_ERROR);
    cov_second_order: cover property (conv_done && cfg_active.order);
endmodule

// File: core/sequencer_pkg.sv
// constants, register map and carrier types of the measurement sequencer
// assumes one 20 MHz clock and an AXI4-Lite master for configuration
package sequencer_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------
    // register map and reset values
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_SIGNATURE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [28:0] CONFIG_RESET = 29'h0;
    localparam logic [15:0] SIGNATURE_RESET = 16'h0000;
    localparam logic [15:0] SIG_SEED = 16'h5a3c;
    localparam logic [15:0] ERROR_CODE = 16'hfe0e; // arbitrary value
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ----------------------------------------
    // field limits
    // ----------------------------------------
    localparam logic [3:0] GAIN_MAX = 4'hc;
    localparam logic [3:0] RES1_MIN = 4'h9;
    localparam logic [3:0] RES1_MAX = 4'he;
    localparam logic [3:0] RES2_MIN = 4'hb;
    localparam logic [3:0] RES2_MAX = 4'hf;
    localparam logic [3:0] ANALOG_RES_MAX = 4'hb;
    localparam logic [3:0] PWM_RES_MAX = 4'hc;
    localparam logic [5:0] OFFSET_NEG_LIMIT = 6'h20;
    localparam logic [5:0] OFFSET_NEG_CLAMP = 6'h21;
    // gain times ten, code 12 first
    localparam logic [12:0][15:0] GAIN_X10 = {16'h001c, 16'h0046, 16'h005d,
        16'h008c, 16'h0107, 16'h015e, 16'h020d, 16'h02bc, 16'h041a, 16'h0578,
        16'h0834, 16'h0af0, 16'h1068};
    // offset factor k times 1000, code 12 first
    localparam logic [12:0][15:0] K_X1000 = {16'h00c8, 16'h04e2, 16'h0729,
        16'h0bb8, 16'h04e2, 16'h0729, 16'h04e2, 16'h0729, 16'h04e2, 16'h0729,
        16'h0bb8, 16'h0729, 16'h0bb8};
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        MUX_OFFSET = 3'b000,
        MUX_BRIDGE = 3'b001,
        MUX_DIODE = 3'b010,
        MUX_BRIDGE_RES = 3'b011,
        MUX_THERMISTOR = 3'b100
    } mux_type;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CHECK = 4'b0001,
        ST_START_AZ = 4'b0010,
        ST_START_P = 4'b0011,
        ST_START_AZT = 4'b0100,
        ST_START_T = 4'b0101,
        ST_P = 4'b0110,
        ST_AZP = 4'b0111,
        ST_AZT = 4'b1000,
        ST_T1 = 4'b1001,
        ST_T2 = 4'b1010,
        ST_ERROR = 4'b1011
    } state_type;
    typedef struct packed {
        logic xzc_en;
        logic diag_high;
        logic [1:0] t2_src;
        logic [1:0] t1_src;
        logic second_temp_enable;
        logic temp_en;
        logic [2:0] plog;
        logic ref_supply;
        logic [3:0] res;
        logic order;
        logic [1:0] range_shift;
        logic [5:0] offset;
        logic [3:0] gain;
    } cfg_type;
    typedef struct packed {
        mux_type tag;
        logic [15:0] count;
    } result_type;
endpackage

// File: verif/front_end_model.sv
// front end stand-in: comparator bit of the modulator
// assumes the bench sets the input level it wants measured
`timescale 1ns/10ps
module front_end_model (
    input wire logic aclk,
    input wire logic level,
    output logic modulator_bit
);
    // a steady level keeps each count exact
    always_ff @(posedge aclk) begin
        modulator_bit <= level;
    end
endmodule

// File: verif/sensor_measurement_sequencer_tb_top.sv
// bench: bus tasks, output queues and a result monitor
// assumes the sequencer package and front end stand-in compiled first
`timescale 1ns/10ps
module sensor_measurement_sequencer_tb_top
    import sequencer_pkg::*;
;
    logic aclk = 0, aresetn = 0, power_on_clear, modulator_bit;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, x = 32'hfe9d, c;
    logic [3:0] s_axi_wstrb, gain_code, analog_res, pwm_res, g;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] gain_x10, offset_factor, serial_word;
    logic [5:0] offset_code;
    logic [10:0] analog_out_code;
    logic result_valid, error_flag, offset_enable;
    mux_type mux_sel;
    result_type result;
    logic [39:0] bq[$], rq[$], pq[$];
    mux_type tags[9] = '{MUX_OFFSET, MUX_BRIDGE, MUX_OFFSET, MUX_DIODE, MUX_BRIDGE,
        MUX_OFFSET, MUX_OFFSET, MUX_DIODE, MUX_THERMISTOR};
    int error_cnt = 0, checked = 0, cycles = 0;
    sensor_measurement_sequencer #(.tick_cycles(2)) u_sensor_measurement_sequencer (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_on_clear, .modulator_bit,
        .gain_code, .gain_x10, .offset_enable, .offset_code, .offset_factor, .mux_sel,
        .result, .result_valid, .error_flag, .analog_out_code, .serial_word,
        .analog_res, .pwm_res);
    front_end_model u_front_end_model (.aclk, .level(1'b1), .modulator_bit);
    always #25 aclk = ~aclk;
    function automatic logic [31:0] xs();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic compare(input logic [39:0] e, input logic [39:0] v);
        checked++;
        if (v !== e) begin
            error_cnt++;
            $display("[ERR] %0t exp %h got %h", $time, e, v);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back({38'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back({6'h0, e});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // ----------------------------------------
    // monitor: oldest note against each answer
    // ----------------------------------------
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (s_axi_bvalid && s_axi_bready) compare(bq.pop_front(), {38'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready)
            compare(rq.pop_front(), {6'h0, s_axi_rresp, s_axi_rdata});
        if (result_valid) compare(pq.pop_front(), {21'h0, result});
        if (cycles == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, power_on_clear} = '0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CONFIG, {RESP_OKAY, 32'h0});
        rd(ADDR_SIGNATURE, {RESP_OKAY, 32'h0});
        rd(8'h20, {RESP_SLVERR, 32'h0});
        wr(ADDR_RESULT, 32'h1, RESP_SLVERR);
        $display("test done: registers");
        // random gain, most negative offset, reference toggled
        for (int i = 0; i < 4; i++) begin
            g = 4'(xs() % 13);
            c = {14'h0, i[0], 7'h0, 6'h20, g};
            wr(ADDR_CONFIG, c, RESP_OKAY);
            rd(ADDR_CONFIG, {RESP_OKAY, c});
            repeat (4) @(posedge aclk);
            compare({1'b0, GAIN_X10[g], K_X1000[g], i[0], i[0] ? 6'h0 : OFFSET_NEG_CLAMP},
                {1'b0, gain_x10, offset_factor, offset_enable, offset_code});
            compare({28'h0, g, RES1_MIN, RES1_MIN}, {28'h0, gain_code, analog_res, pwm_res});
        end
        $display("test done: front end");
        // 9 bit first order, half range shift: 512 + 256, both temperatures on
        foreach (tags[i]) pq.push_back({21'h0, tags[i], 16'h0300});
        wr(ADDR_CONFIG, 32'h04612c00, RESP_OKAY);
        wr(ADDR_SIGNATURE, 32'h725d, RESP_OKAY);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        while (pq.size() != 0) @(posedge aclk);
        compare({13'h0, 16'h0300, 11'h300}, {13'h0, serial_word, analog_out_code});
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        $display("test done: measurement cycle");
        wr(ADDR_CONFIG, 32'h08000000, RESP_OKAY);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        repeat (8) @(posedge aclk);
        compare({12'h0, 1'b1, ERROR_CODE, 11'h7ff},
            {12'h0, error_flag, serial_word, analog_out_code});
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        power_on_clear <= 1'b1;
        repeat (4) @(posedge aclk);
        power_on_clear <= 1'b0;
        repeat (6) @(posedge aclk);
        compare(40'h0, {39'h0, error_flag});
        $display("test done: diagnostics");
        end_of_test();
    end
endmodule
